// ### rtl/eep_pkg.sv
// Shared constants for the serial EEPROM link ends
package eep_pkg;
    // ==========================================================
    // Data and array organisation
    localparam int BYTE_W = 8;
    localparam int ARRAY_BYTES = 131072;
    localparam int ADDR_W = $clog2(ARRAY_BYTES);
    localparam int ADDR_BYTES = (ADDR_W + BYTE_W - 1) / BYTE_W;
    localparam int BIT_CNT_W = $clog2(BYTE_W);

    // ==========================================================
    // Instruction codes
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;

    // ==========================================================
    // Timing of the master-made serial clock
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCLK_HALF_NS = 100;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ==========================================================
    // Reset values of link pins driven by the master
    localparam logic CS_N_RST = 1'b1;
    localparam logic HOLD_N_RST = 1'b1;
    localparam logic WP_N_RST = 1'b1;
endpackage : eep_pkg

// ### rtl/eep_spi_if.sv
// Serial link between the bus master and the EEPROM front end
`timescale 1ns/1ps
`default_nettype none
interface eep_spi_if;
    logic sclk;
    logic cs_n;
    logic d;
    logic hold_n;
    logic wp_n;
    logic q_o;
    logic q_oe;
    logic q;

    // Floating data line reads high, as with a bus pull-up
    assign q = q_oe ? q_o : 1'b1;

    modport host (
        output sclk, cs_n, d, hold_n, wp_n,
        input q
    );
    modport dev (
        input sclk, cs_n, d, hold_n, wp_n,
        output q_o, q_oe
    );
endinterface : eep_spi_if
`default_nettype wire

// ### rtl/eep_sync.sv
// Two-stage synchroniser for a bundle of independent levels
`timescale 1ns/1ps
`default_nettype none
module eep_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Destination clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Levels in and out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // First stage is read only by the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // eep_sync
`default_nettype wire

// ### rtl/eep_dev_end.sv
// EEPROM serial front end, clocked by the master's serial clock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Output bit changes on falling clock edges
// - Input bits captured on rising clock edges
// - Select high deselects and floats output
// - Deselected means standby unless write running
// - Select low means selected and active
// - Ignore everything until first select falling edge
// - Hold pauses without losing bit sequence
// - During hold output floats, inputs ignored
// - Hold only honoured while selected
// - Write-protect locks protected region size
// - Master keeps write-protect stable during writes
// - Input bytes arrive most significant bit first
// - First bit on first rise after select
// - Output bytes leave most significant bit first
// - Read data starts at fall after instruction
// - Only modes zero and three are supported
// - Array holds 131072 bytes of eight bits
// - Hold enters and leaves with clock low
// - Deselect during hold resets interface logic
// - Select rise between last rise and next
// - Unknown instruction deselects internally until select rises
module eep_dev_end
    import eep_pkg::*;
(
    // System clock and power-on reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial link
    eep_spi_if.dev spi,
    // Received byte stream
    output logic [BYTE_W-1:0] o_rx_byte,
    output logic o_rx_valid,
    output logic o_frame_end,
    output logic o_frame_whole,
    // Outgoing byte for read-type instructions
    input wire logic [BYTE_W-1:0] i_tx_byte,
    input wire logic i_tx_load,
    output logic o_tx_req,
    // Array state and power
    input wire logic i_write_in_progress,
    output logic o_standby,
    output logic o_wp_lock
);
    // ==========================================================
    // Power-up arming on the select falling edge
    logic armed_r;
    logic link_rst_n;

    // Clocked by the select pin itself, so a select that is already low
    // when reset releases never arms the link
    always_ff @(negedge spi.cs_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_r <= 1'b0;
        end else begin
            armed_r <= 1'b1;
        end
    end

    // Shifting, instruction and output logic is held cleared while deselected or not yet armed
    assign link_rst_n = i_rst_n & ~spi.cs_n & armed_r;

    // ==========================================================
    // Link domain: input shifting and instruction tracking
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [BYTE_W-2:0] sh_r;
    logic [2:0] byte_cnt_r;
    logic [7:0] opcode_r;
    logic bad_r;
    logic out_phase_r;
    logic [BYTE_W-1:0] rx_byte_r;
    logic rx_tgl_r;
    logic partial_r;
    logic tx_tgl_r;
    logic [BYTE_W-1:0] tx_sh_r;
    logic q_oe_r;
    logic [BYTE_W-1:0] tx_hold_r;

    logic shift_en;
    logic byte_full;
    logic first_byte;
    logic [BYTE_W-1:0] rx_word;
    logic op_known;
    logic out_start;
    logic [2:0] byte_cnt_nxt;

    // Hold sampled at the rising edge was low while the clock was low
    assign shift_en = spi.hold_n & ~bad_r;
    assign byte_full = (bit_cnt_r == BIT_CNT_W'(BYTE_W - 1));
    assign first_byte = (byte_cnt_r == 3'h0);
    assign rx_word = {sh_r, spi.d};
    assign op_known = (rx_word == OP_WRSR) || (rx_word == OP_WRITE) || (rx_word == OP_READ)
        || (rx_word == OP_WRDI) || (rx_word == OP_RDSR) || (rx_word == OP_WREN);
    // RDSR answers right after its code, READ after the address bytes
    assign out_start = byte_full && ((first_byte && rx_word == OP_RDSR)
        || (byte_cnt_r == 3'(ADDR_BYTES) && opcode_r == OP_READ));
    assign byte_cnt_nxt = (byte_cnt_r == 3'h7) ? byte_cnt_r : byte_cnt_r + 3'h1;

    // Capture on the rising edge; the first rise after select is bit 0
    always_ff @(posedge spi.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_r <= '0;
            sh_r <= '0;
            byte_cnt_r <= '0;
            opcode_r <= '0;
            bad_r <= 1'b0;
            out_phase_r <= 1'b0;
        end else if (shift_en) begin
            bit_cnt_r <= bit_cnt_r + BIT_CNT_W'(1);
            sh_r <= rx_word[BYTE_W-2:0];
            if (byte_full) begin
                byte_cnt_r <= byte_cnt_nxt;
            end
            if (byte_full && first_byte) begin
                opcode_r <= rx_word;
                bad_r <= ~op_known;
            end
            if (out_start) begin
                out_phase_r <= 1'b1;
            end
        end
    end

    // Byte hand-off and partial-byte flag survive the select rise
    always_ff @(posedge spi.sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_byte_r <= '0;
            rx_tgl_r <= 1'b0;
            partial_r <= 1'b0;
        end else if (link_rst_n && shift_en) begin
            partial_r <= ~byte_full;
            if (byte_full) begin
                rx_byte_r <= rx_word;
                rx_tgl_r <= ~rx_tgl_r;
            end
        end
    end

    // Next byte is asked for only once the current one has been copied
    // out, so a fast loader can never overwrite a byte before it is used
    always_ff @(negedge spi.sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_tgl_r <= 1'b0;
        end else if (link_rst_n && spi.hold_n && out_phase_r && bit_cnt_r == '0) begin
            tx_tgl_r <= ~tx_tgl_r;
        end
    end

    // ==========================================================
    // Link domain: output shifting on the falling edge
    always_ff @(negedge spi.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_sh_r <= '0;
            q_oe_r <= 1'b0;
        end else if (spi.hold_n) begin
            q_oe_r <= out_phase_r & ~bad_r;
            if (bit_cnt_r == '0) begin
                tx_sh_r <= tx_hold_r;
            end else begin
                tx_sh_r <= {tx_sh_r[BYTE_W-2:0], 1'b0};
            end
        end else begin
            q_oe_r <= 1'b0;
        end
    end

    // Select high clears the enable flop at once; hold floats the pin at
    // once too, since the clock stands still for the whole pause
    assign spi.q_o = tx_sh_r[BYTE_W-1];
    assign spi.q_oe = q_oe_r & spi.hold_n;

    // ==========================================================
    // System domain: crossing and user side
    logic [3:0] sync_out;
    logic cs_s;
    logic rx_tgl_s;
    logic tx_tgl_s;
    logic wp_s;
    logic cs_d_r;
    logic rx_tgl_d_r;
    logic tx_tgl_d_r;

    eep_sync #(
        .WIDTH(4),
        .RST_VAL(4'h9)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({spi.cs_n, rx_tgl_r, tx_tgl_r, spi.wp_n}),
        .o_sync(sync_out)
    );

    assign cs_s = sync_out[3];
    assign rx_tgl_s = sync_out[2];
    assign tx_tgl_s = sync_out[1];
    assign wp_s = sync_out[0];

    // Outgoing byte is quasi-static: it must be loaded before it is due
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_hold_r <= '0;
        end else if (i_tx_load) begin
            tx_hold_r <= i_tx_byte;
        end
    end

    // Edge detection and registered user outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_d_r <= 1'b1;
            rx_tgl_d_r <= 1'b0;
            tx_tgl_d_r <= 1'b0;
            o_rx_byte <= '0;
            o_rx_valid <= 1'b0;
            o_frame_end <= 1'b0;
            o_frame_whole <= 1'b0;
            o_tx_req <= 1'b0;
            o_standby <= 1'b1;
            o_wp_lock <= 1'b0;
        end else begin
            cs_d_r <= cs_s;
            rx_tgl_d_r <= rx_tgl_s;
            tx_tgl_d_r <= tx_tgl_s;
            o_rx_valid <= rx_tgl_s ^ rx_tgl_d_r;
            if (rx_tgl_s ^ rx_tgl_d_r) begin
                o_rx_byte <= rx_byte_r;
            end
            o_tx_req <= tx_tgl_s ^ tx_tgl_d_r;
            o_frame_end <= cs_s & ~cs_d_r & armed_r;
            if (cs_s & ~cs_d_r) begin
                o_frame_whole <= ~partial_r;
            end
            o_standby <= cs_s & ~i_write_in_progress;
            o_wp_lock <= ~wp_s;
        end
    end
endmodule // eep_dev_end
`default_nettype wire

// ### rtl/eep_host_end.sv
// Bus master end: makes the serial clock and frames byte transfers
`timescale 1ns/1ps
`default_nettype none
module eep_host_end
    import eep_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter bit CPOL = 1'b0
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial link
    eep_spi_if.host spi,
    // Byte command stream
    input wire logic i_cmd_valid,
    input wire logic [BYTE_W-1:0] i_cmd_byte,
    input wire logic i_cmd_last,
    output logic o_cmd_ready,
    // Received bytes
    output logic [BYTE_W-1:0] o_rx_byte,
    output logic o_rx_valid,
    // Hold and write-protect requests
    input wire logic i_hold_req,
    output logic o_held,
    input wire logic i_wp_n
);
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_WAIT, ST_END, ST_GAP} eep_st_e;

    eep_st_e st_r;
    eep_st_e st_nxt;
    localparam int CNT_W = $clog2(HALF_CYC + 1);
    logic [CNT_W-1:0] cnt_r;
    logic [BIT_CNT_W-1:0] bit_r;
    logic [BYTE_W-1:0] tx_r;
    logic [BYTE_W-1:0] rxs_r;
    logic last_r;
    logic hold_n_r;
    logic sclk_r;
    logic cs_n_r;
    logic wp_n_r;
    logic q_s;

    logic tick;
    logic accept;
    logic can_hold;
    logic byte_done;

    // ==========================================================
    // Data line from the device passes two flops first
    eep_sync #(
        .WIDTH(1),
        .RST_VAL(1'b1)
    ) u_qsync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(spi.q),
        .o_sync(q_s)
    );

    // ==========================================================
    // Sequencing
    assign tick = (cnt_r == CNT_W'(HALF_CYC - 1)) && hold_n_r;
    assign accept = i_cmd_valid & o_cmd_ready;
    // Hold only with clock and select low, never on the edge that raises the clock
    assign can_hold = ((st_r == ST_LOW && !tick) || st_r == ST_WAIT) && !cs_n_r;
    assign byte_done = (bit_r == BIT_CNT_W'(BYTE_W - 1));

    // Next state: select rises two half periods after the last rising edge
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: st_nxt = accept ? ST_LEAD : ST_IDLE;
            ST_LEAD: st_nxt = tick ? ST_LOW : ST_LEAD;
            ST_LOW: st_nxt = tick ? ST_HIGH : ST_LOW;
            ST_HIGH: begin
                if (tick) begin
                    st_nxt = !byte_done ? ST_LOW : (last_r ? ST_END : ST_WAIT);
                end
            end
            ST_WAIT: st_nxt = accept ? ST_LOW : ST_WAIT;
            ST_END: st_nxt = tick ? ST_GAP : ST_END;
            ST_GAP: st_nxt = tick ? ST_IDLE : ST_GAP;
        endcase
    end

    // State and half-period timer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            // A hold restarts the half period so the data line settles again
            if (st_nxt != st_r || tick || !hold_n_r) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end

    // Shift registers: data out most significant bit first
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_r <= '0;
            rxs_r <= '0;
            bit_r <= '0;
            last_r <= 1'b0;
        end else begin
            if (accept) begin
                tx_r <= i_cmd_byte;
                last_r <= i_cmd_last;
                bit_r <= '0;
            end else if (st_r == ST_LOW && tick) begin
                rxs_r <= {rxs_r[BYTE_W-2:0], q_s};
            end else if (st_r == ST_HIGH && tick && !byte_done) begin
                tx_r <= {tx_r[BYTE_W-2:0], 1'b0};
                bit_r <= bit_r + BIT_CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // Registered pins and user outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_r <= CPOL;
            cs_n_r <= CS_N_RST;
            hold_n_r <= HOLD_N_RST;
            wp_n_r <= WP_N_RST;
            o_cmd_ready <= 1'b0;
            o_rx_byte <= '0;
            o_rx_valid <= 1'b0;
            o_held <= 1'b0;
        end else begin
            // Idle level sets the mode; data edges are the same in both
            sclk_r <= (st_nxt == ST_HIGH) | (CPOL & (st_nxt == ST_IDLE || st_nxt == ST_LEAD
                || st_nxt == ST_END || st_nxt == ST_GAP));
            cs_n_r <= (st_nxt == ST_IDLE || st_nxt == ST_GAP);
            if (st_r == ST_IDLE) begin
                wp_n_r <= i_wp_n;
            end
            if (can_hold && i_hold_req) begin
                hold_n_r <= 1'b0;
            end else if (can_hold || cs_n_r) begin
                hold_n_r <= 1'b1;
            end
            o_held <= ~hold_n_r;
            o_cmd_ready <= (st_nxt == ST_IDLE || st_nxt == ST_WAIT) && !accept;
            o_rx_valid <= (st_r == ST_HIGH) && tick && byte_done;
            if ((st_r == ST_HIGH) && tick && byte_done) begin
                o_rx_byte <= rxs_r;
            end
        end
    end

    assign spi.sclk = sclk_r;
    assign spi.cs_n = cs_n_r;
    assign spi.d = tx_r[BYTE_W-1];
    assign spi.hold_n = hold_n_r;
    assign spi.wp_n = wp_n_r;
endmodule // eep_host_end
`default_nettype wire

// ### dv/eep_link_sva.sv
// Concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module eep_link_sva #(
    parameter bit CPOL = 1'b0
) (
    // Sampling clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic d,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic q_o,
    input wire logic q_oe,
    input wire logic q
);
    // ==========================================================
    // Link rules, sampled on the fast clock that makes the serial clock
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_q_float_desel: assert property (cs_n |-> !q_oe)
        else $error("data output driven while deselected");
    a_q_fall_only: assert property ((!cs_n && q_oe && $changed(q_o)) |-> $fell(sclk))
        else $error("data output changed away from a falling clock edge");
    a_oe_at_fall: assert property ($rose(q_oe) |-> ($fell(sclk) || $rose(hold_n)))
        else $error("output phase began away from a falling clock edge");
    a_d_stable_rise: assert property ((!cs_n && $changed(d)) |-> !sclk)
        else $error("data input moved while the clock was high");
    a_idle_clk_level: assert property (cs_n |-> (sclk == CPOL))
        else $error("serial clock off its idle level while deselected");
    a_hold_enter_low: assert property ($fell(hold_n) |-> !sclk)
        else $error("hold entered with the clock high");
    a_hold_leave_low: assert property ($rose(hold_n) |-> !sclk)
        else $error("hold left with the clock high");
    a_hold_selected: assert property (!hold_n |-> !cs_n)
        else $error("hold asserted while deselected");
    a_q_float_hold: assert property (!hold_n |-> !q_oe)
        else $error("data output driven during hold");
    a_wp_frame_stable: assert property ((!cs_n && !$fell(cs_n)) |-> $stable(wp_n))
        else $error("write protect moved inside a frame");
    a_first_bit_lead: assert property ($fell(cs_n) |-> !sclk [*3])
        else $error("clock rose too soon after select");
    a_select_gap: assert property ($rose(cs_n) |-> cs_n [*3])
        else $error("select low again without a gap");
endmodule // eep_link_sva
`default_nettype wire

// ### dv/spi_eeprom_serial_port_tb_top.sv
// Self-checking bench joining the master end and the device end
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_serial_port_tb_top;
    import eep_pkg::*;
    // Short half period keeps the run brief
    localparam int HC = 4;
    // ==========================================================
    // Signals
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic cmd_last = 1'b0;
    logic hold_req = 1'b0;
    logic wp_n = 1'b1;
    logic write_in_progress = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic tx_load = 1'b0;
    logic cmd_ready, h_rx_valid, held, d_rx_valid, d_frame_end, d_frame_whole, d_tx_req;
    logic d_standby, d_wp_lock;
    logic [7:0] h_rx_byte, d_rx_byte;
    logic [15:0] lfsr = 16'h3C0D;
    logic [7:0] fb [8];
    logic [7:0] tx_vals [3];
    logic [7:0] h_exp [$];
    logic [7:0] d_exp [$];
    logic f_exp [$];
    int n_fail = 0;
    int n_compared = 0;
    int tx_ptr = 3;
    int dev_rx_cnt = 0;
    int cnt;
    bit chk_dev = 1'b1;

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    // ==========================================================
    // Both ends face each other across one interface
    eep_spi_if spi_bus ();
    eep_host_end #(.HALF_CYC(HC), .CPOL(1'b0)) eep_host_end_inst (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .spi(spi_bus), .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte),
        .i_cmd_last(cmd_last), .o_cmd_ready(cmd_ready), .o_rx_byte(h_rx_byte),
        .o_rx_valid(h_rx_valid), .i_hold_req(hold_req), .o_held(held), .i_wp_n(wp_n));
    eep_dev_end eep_dev_end_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .spi(spi_bus),
        .o_rx_byte(d_rx_byte), .o_rx_valid(d_rx_valid), .o_frame_end(d_frame_end),
        .o_frame_whole(d_frame_whole), .i_tx_byte(tx_byte), .i_tx_load(tx_load),
        .o_tx_req(d_tx_req), .i_write_in_progress(write_in_progress), .o_standby(d_standby),
        .o_wp_lock(d_wp_lock));
    eep_link_sva #(.CPOL(1'b0)) eep_link_sva_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .sclk(spi_bus.sclk), .cs_n(spi_bus.cs_n), .d(spi_bus.d), .hold_n(spi_bus.hold_n),
        .wp_n(spi_bus.wp_n), .q_o(spi_bus.q_o), .q_oe(spi_bus.q_oe), .q(spi_bus.q));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic unexpected(input string what);
        n_fail++;
        $display("mismatch at %0t: unexpected %s", $time, what);
    endtask

    // Bounded wait for the master end to take a byte
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 5000) begin
            unexpected("stall of the master end");
            give_verdict();
        end
    endtask

    // Hold request in mid-frame, released after a while
    task automatic pause(input int at);
        int n;
        repeat (at) @(posedge i_clk);
        #1;
        hold_req = 1'b1;
        for (n = 0; n < 100 && held !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        chk_bit(held, 1'b1, "held");
        chk_bit(d_standby, 1'b0, "active while selected");
        repeat (20) @(posedge i_clk);
        #1;
        hold_req = 1'b0;
    endtask

    task automatic put_byte(input logic [7:0] b, input logic last);
        @(posedge i_clk);
        #1;
        wait_ready();
        cmd_valid = 1'b1;
        cmd_byte = b;
        cmd_last = last;
        @(posedge i_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_last = 1'b0;
    endtask

    // One frame; hdr > 0 marks a read-type frame whose output starts after hdr bytes
    task automatic frame(input logic [7:0] op, input int n, input int hdr);
        int i;
        fb[0] = op;
        for (i = 1; i < n; i++) begin
            fb[i] = rnd();
        end
        if (hdr > 0) begin
            for (i = 0; i < 3; i++) begin
                tx_vals[i] = rnd();
            end
            tx_ptr = 0;
        end
        if (chk_dev) f_exp.push_back(1'b1);
        for (i = 0; i < n; i++) begin
            h_exp.push_back((hdr > 0 && i >= hdr) ? tx_vals[i - hdr] : 8'hFF);
            if (chk_dev) d_exp.push_back(fb[i]);
            put_byte(fb[i], i == n - 1);
        end
        repeat (2) @(posedge i_clk);
        #1;
        wait_ready();
        repeat (12) @(posedge i_clk);
        #1;
    endtask

    // ==========================================================
    // Output byte feeder: first byte at once, later ones on request
    always @(posedge i_clk) begin
        #1;
        tx_load = 1'b0;
        if ((d_tx_req === 1'b1 || tx_ptr == 0) && tx_ptr < 3) begin
            tx_byte = tx_vals[tx_ptr];
            tx_ptr++;
            tx_load = 1'b1;
        end
    end

    // Watchers take the oldest note whenever a result appears
    always @(negedge i_clk) begin
        if (h_rx_valid === 1'b1) begin
            if (h_exp.size() > 0) chk_byte(h_rx_byte, h_exp.pop_front(), "host rx");
            else unexpected("host byte");
        end
        if (d_rx_valid === 1'b1) begin
            dev_rx_cnt++;
            if (chk_dev && d_exp.size() > 0) chk_byte(d_rx_byte, d_exp.pop_front(), "dev rx");
            else if (chk_dev) unexpected("device byte");
        end
        if (d_frame_end === 1'b1 && chk_dev) begin
            if (f_exp.size() > 0) chk_bit(d_frame_whole, f_exp.pop_front(), "whole");
            else unexpected("frame end");
        end
    end

    initial begin
        #200000;
        unexpected("run length");
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        // Hold in mid-byte of a write frame
        fork
            pause(60);
        join_none
        frame(OP_WRITE, 6, 0);
        wp_n = 1'b0;
        frame(OP_WREN, 1, 0);
        chk_bit(d_wp_lock, 1'b1, "lock on");
        wp_n = 1'b1;
        frame(OP_WRDI, 1, 0);
        chk_bit(d_wp_lock, 1'b0, "lock off");
        frame(OP_WRSR, 2, 0);
        chk_dev = 1'b0;
        frame(OP_RDSR, 2, 1);
        // Hold while the device drives read data
        fork
            pause(330);
        join_none
        frame(OP_READ, 7, 4);
        cnt = dev_rx_cnt;
        frame(8'hA5, 3, 0);
        chk_bit(dev_rx_cnt - cnt <= 1, 1'b1, "unknown opcode ignored");
        chk_dev = 1'b1;
        frame(OP_WRITE, 5, 0);
        write_in_progress = 1'b1;
        repeat (10) @(posedge i_clk);
        #1;
        chk_bit(d_standby, 1'b0, "busy while writing");
        write_in_progress = 1'b0;
        repeat (10) @(posedge i_clk);
        #1;
        chk_bit(d_standby, 1'b1, "standby");
        // Second reset in mid-run
        i_rst_n = 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        chk_bit(d_standby, 1'b1, "standby in reset");
        chk_bit(cmd_ready, 1'b0, "ready in reset");
        i_rst_n = 1'b1;
        frame(OP_WRITE, 4, 0);
        give_verdict();
    end
endmodule // spi_eeprom_serial_port_tb_top
`default_nettype wire
